// *** io_line_cfg.svh ***
// Constants for the I/O line configuration and status bank.
// Assumes a 32-bit Wishbone word bus with byte addresses on wb_adr.
`ifndef IO_LINE_CFG_SVH
`define IO_LINE_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IOL_OFS_CHANGE_STATUS   8'h00
`define IOL_OFS_OD_ENABLE       8'h04
`define IOL_OFS_OD_DISABLE      8'h08
`define IOL_OFS_OD_STATUS       8'h0c
`define IOL_OFS_PU_DISABLE      8'h10
`define IOL_OFS_PU_ENABLE       8'h14
`define IOL_OFS_PU_STATUS       8'h18
`define IOL_OFS_FUNC_A_SELECT   8'h1c
`define IOL_OFS_FUNC_B_SELECT   8'h20
`define IOL_OFS_FUNC_STATUS     8'h24
`define IOL_OFS_DW_ENABLE       8'h28
`define IOL_OFS_DW_DISABLE      8'h2c
`define IOL_OFS_DW_STATUS       8'h30
`define IOL_OFS_OUT_LEVEL       8'h34
`define IOL_OFS_IRQ_MASK        8'h38

// ----------------------------------------------------------------------
// Field layout of the word address
// ----------------------------------------------------------------------
`define IOL_ADR_WORD_MSB        7
`define IOL_ADR_WORD_LSB        2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IOL_RST_CHANGE          32'h0000_0000
`define IOL_RST_OPEN_DRAIN      32'h0000_0000
`define IOL_RST_PULLUP_ON       32'hffff_ffff
`define IOL_RST_FUNC_B          32'h0000_0000
`define IOL_RST_DIRECT_WRITE    32'h0000_0000
`define IOL_RST_OUT_LEVEL       32'h0000_0000
`define IOL_RST_IRQ_MASK        32'h0000_0000

`endif

// *** io_line_pkg.sv ***
// Types shared by the I/O line configuration and status bank.
// Assumes the constants of io_line_cfg.svh for offsets and resets.
package io_line_pkg;

    typedef logic [31:0] line_vec_t;
    typedef logic [7:0]  bus_addr_t;
    typedef logic [3:0]  lane_sel_t;

endpackage : io_line_pkg

// *** io_line_sc_if.sv ***
// Set/clear carrier between the bank and its setting registers.
// Assumes one clock; set and clear are one-cycle bit masks.
`timescale 1ns/100ps

interface io_line_sc_if;
    io_line_pkg::line_vec_t set_bits;
    io_line_pkg::line_vec_t clr_bits;
    io_line_pkg::line_vec_t state;

    modport ctl  (output set_bits, output clr_bits, input state);
    modport bank (input set_bits, input clr_bits, output state);
endinterface : io_line_sc_if

// *** io_line_sync.sv ***
// Two-stage synchroniser for the 32 pad input levels.
// Assumes pads are asynchronous to mclk.
`timescale 1ns/100ps

module io_line_sync (
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire io_line_pkg::line_vec_t raw,
    output io_line_pkg::line_vec_t      synced
);
    io_line_pkg::line_vec_t meta;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta   <= 32'h0000_0000;
            synced <= 32'h0000_0000;
        end else begin
            meta   <= raw;
            synced <= meta;
        end
    end
endmodule : io_line_sync

// *** io_line_setclr.sv ***
// One 32-line setting held by set and clear write masks.
// Assumes set and clear come from register writes on mclk.
`timescale 1ns/100ps

module io_line_setclr #(
    parameter io_line_pkg::line_vec_t RESET_VAL = 32'h0000_0000
) (
    input  wire logic   mclk,
    input  wire logic   rst_b,
    io_line_sc_if.bank  sc
);
    io_line_pkg::line_vec_t next_state;

    // Clear wins should both ever meet on one bit
    assign next_state = (sc.state | sc.set_bits) & ~sc.clr_bits;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sc.state <= RESET_VAL;
        end else begin
            sc.state <= next_state;
        end
    end
endmodule : io_line_setclr

// *** io_line_config_status_bank.sv ***
// I/O line configuration and status bank with a Wishbone slave.
// Assumes a classic Wishbone master on mclk, asynchronous pads, and
// line ownership, drive enables and peripheral signals on mclk.
//
// Functional notes
// - Bit n of every register is line n.
// - Detected input change sets line status bit.
// - Reading change status clears all its bits.
// - Open-drain enable writes ones turn it on.
// - Open-drain disable writes ones turn it off.
// - Open-drain off: pin driven high and low.
// - Open-drain on: pin only pulled low.
// - Pull-up disable writes ones switch it off.
// - Pull-up enable writes ones switch it on.
// - Pull-up status reads zero when pull-up on.
// - Function A select routes line to first.
// - Function B select routes line to second.
// - Function status reads zero A, one B.
// - Direct-write enable opens output data writes.
// - Direct-write disable blocks output data writes.
// - Blocked line keeps output data on write.
// - Open line takes written output data bit.
// - Output data register is read-write, shows level.
// - Interrupt mask reads one where line enabled.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "io_line_cfg.svh"

module io_line_config_status_bank (
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire logic                   wb_cyc,
    input  wire logic                   wb_stb,
    input  wire logic                   wb_we,
    input  wire io_line_pkg::bus_addr_t wb_adr,
    input  wire io_line_pkg::lane_sel_t wb_sel,
    input  wire io_line_pkg::line_vec_t wb_dat_w,
    output io_line_pkg::line_vec_t      wb_dat_r,
    output logic                        wb_ack,
    input  wire io_line_pkg::line_vec_t pin_in,
    input  wire io_line_pkg::line_vec_t line_pio_owned,
    input  wire io_line_pkg::line_vec_t line_drive_en,
    input  wire io_line_pkg::line_vec_t periph_a_dout,
    input  wire io_line_pkg::line_vec_t periph_a_oe,
    input  wire io_line_pkg::line_vec_t periph_b_dout,
    input  wire io_line_pkg::line_vec_t periph_b_oe,
    output io_line_pkg::line_vec_t      pin_out,
    output io_line_pkg::line_vec_t      pin_oe,
    output io_line_pkg::line_vec_t      pullup_on,
    output io_line_pkg::line_vec_t      func_b_route,
    output logic                        change_irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Word compare; the two low byte-address bits are ignored
    function automatic logic word_hit(
        input io_line_pkg::bus_addr_t adr,
        input io_line_pkg::bus_addr_t ofs
    );
        word_hit = adr[`IOL_ADR_WORD_MSB:`IOL_ADR_WORD_LSB]
                   == ofs[`IOL_ADR_WORD_MSB:`IOL_ADR_WORD_LSB];
    endfunction : word_hit

    // Byte enables widened to a bit mask so partial writes stay local
    function automatic io_line_pkg::line_vec_t lane_mask(
        input io_line_pkg::lane_sel_t sel
    );
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire logic                   req_live;
    wire logic                   wr_live;
    wire logic                   rd_live;
    wire io_line_pkg::line_vec_t wr_bits;

    wire logic                   hit_change;
    wire logic                   hit_od_en;
    wire logic                   hit_od_dis;
    wire logic                   hit_od_stat;
    wire logic                   hit_pu_dis;
    wire logic                   hit_pu_en;
    wire logic                   hit_pu_stat;
    wire logic                   hit_fa_sel;
    wire logic                   hit_fb_sel;
    wire logic                   hit_fs_stat;
    wire logic                   hit_dw_en;
    wire logic                   hit_dw_dis;
    wire logic                   hit_dw_stat;
    wire logic                   hit_out_level;
    wire logic                   hit_mask;

    // A request is served once; ack high blocks a second take
    assign req_live = wb_cyc & wb_stb & ~wb_ack;
    assign wr_live  = req_live & wb_we;
    assign rd_live  = req_live & ~wb_we;
    assign wr_bits  = wb_dat_w & lane_mask(wb_sel);

    // Unmapped words hit nothing and fall to the zero read below
    assign hit_change    = word_hit(wb_adr, `IOL_OFS_CHANGE_STATUS);
    assign hit_od_en     = word_hit(wb_adr, `IOL_OFS_OD_ENABLE);
    assign hit_od_dis    = word_hit(wb_adr, `IOL_OFS_OD_DISABLE);
    assign hit_od_stat   = word_hit(wb_adr, `IOL_OFS_OD_STATUS);
    assign hit_pu_dis    = word_hit(wb_adr, `IOL_OFS_PU_DISABLE);
    assign hit_pu_en     = word_hit(wb_adr, `IOL_OFS_PU_ENABLE);
    assign hit_pu_stat   = word_hit(wb_adr, `IOL_OFS_PU_STATUS);
    assign hit_fa_sel    = word_hit(wb_adr, `IOL_OFS_FUNC_A_SELECT);
    assign hit_fb_sel    = word_hit(wb_adr, `IOL_OFS_FUNC_B_SELECT);
    assign hit_fs_stat   = word_hit(wb_adr, `IOL_OFS_FUNC_STATUS);
    assign hit_dw_en     = word_hit(wb_adr, `IOL_OFS_DW_ENABLE);
    assign hit_dw_dis    = word_hit(wb_adr, `IOL_OFS_DW_DISABLE);
    assign hit_dw_stat   = word_hit(wb_adr, `IOL_OFS_DW_STATUS);
    assign hit_out_level = word_hit(wb_adr, `IOL_OFS_OUT_LEVEL);
    assign hit_mask      = word_hit(wb_adr, `IOL_OFS_IRQ_MASK);

    // ------------------------------------------------------------------
    // Set/clear settings
    // ------------------------------------------------------------------
    io_line_sc_if od_sc ();
    io_line_sc_if pu_sc ();
    io_line_sc_if fs_sc ();
    io_line_sc_if dw_sc ();

    // Masks live one cycle only, while the request is taken
    assign od_sc.set_bits = (wr_live & hit_od_en)  ? wr_bits : '0;
    assign od_sc.clr_bits = (wr_live & hit_od_dis) ? wr_bits : '0;
    assign pu_sc.set_bits = (wr_live & hit_pu_en)  ? wr_bits : '0;
    assign pu_sc.clr_bits = (wr_live & hit_pu_dis) ? wr_bits : '0;
    assign fs_sc.set_bits = (wr_live & hit_fb_sel) ? wr_bits : '0;
    assign fs_sc.clr_bits = (wr_live & hit_fa_sel) ? wr_bits : '0;
    assign dw_sc.set_bits = (wr_live & hit_dw_en)  ? wr_bits : '0;
    assign dw_sc.clr_bits = (wr_live & hit_dw_dis) ? wr_bits : '0;

    io_line_setclr #(
        .RESET_VAL (`IOL_RST_OPEN_DRAIN)
    ) u_open_drain (
        .mclk  (mclk),
        .rst_b (rst_b),
        .sc    (od_sc.bank)
    );

    // Pull-ups start on so released lines rest at a known level
    io_line_setclr #(
        .RESET_VAL (`IOL_RST_PULLUP_ON)
    ) u_pullup (
        .mclk  (mclk),
        .rst_b (rst_b),
        .sc    (pu_sc.bank)
    );

    // Stored bit means route B; an A select clears it
    io_line_setclr #(
        .RESET_VAL (`IOL_RST_FUNC_B)
    ) u_func_sel (
        .mclk  (mclk),
        .rst_b (rst_b),
        .sc    (fs_sc.bank)
    );

    // Direct writes start closed; one enable write opens any set of lines
    io_line_setclr #(
        .RESET_VAL (`IOL_RST_DIRECT_WRITE)
    ) u_direct_write (
        .mclk  (mclk),
        .rst_b (rst_b),
        .sc    (dw_sc.bank)
    );

    // ------------------------------------------------------------------
    // Output data and interrupt mask
    // ------------------------------------------------------------------
    io_line_pkg::line_vec_t  out_level;
    io_line_pkg::line_vec_t  change_irq_mask;

    wire io_line_pkg::line_vec_t dw_gate;
    wire io_line_pkg::line_vec_t next_out_level;
    wire io_line_pkg::line_vec_t mask_gate;
    wire io_line_pkg::line_vec_t next_mask;

    // Byte enables apply to output data and mask as to settings
    // Lines closed to direct writes keep their level
    assign dw_gate        = (wr_live & hit_out_level)
                            ? (lane_mask(wb_sel) & dw_sc.state) : '0;
    assign next_out_level = (out_level & ~dw_gate)
                            | (wb_dat_w & dw_gate);
    assign mask_gate      = (wr_live & hit_mask) ? lane_mask(wb_sel) : '0;
    assign next_mask      = (change_irq_mask & ~mask_gate)
                            | (wb_dat_w & mask_gate);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            out_level       <= `IOL_RST_OUT_LEVEL;
        end else begin
            out_level       <= next_out_level;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            change_irq_mask <= `IOL_RST_IRQ_MASK;
        end else begin
            change_irq_mask <= next_mask;
        end
    end

    // ------------------------------------------------------------------
    // Input change detection
    // ------------------------------------------------------------------
    io_line_pkg::line_vec_t  pin_level;
    io_line_pkg::line_vec_t  pin_prev;
    logic                    prev_valid;
    io_line_pkg::line_vec_t  change_status;

    wire io_line_pkg::line_vec_t change_seen;
    wire io_line_pkg::line_vec_t read_clear;
    wire io_line_pkg::line_vec_t next_change;

    // Detection sees the pads only after two synchroniser flops
    io_line_sync u_pin_sync (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .raw    (pin_in),
        .synced (pin_level)
    );

    // No compare in the first cycle after reset; first pad levels are still compared with the synchroniser's reset zero
    assign change_seen = prev_valid ? (pin_level ^ pin_prev) : '0;
    assign read_clear  = (rd_live & hit_change) ? '1 : '0;
    // A change in the read-clear cycle survives into the next read
    assign next_change = (change_status & ~read_clear)
                         | change_seen;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_prev      <= 32'h0000_0000;
            prev_valid    <= 1'b0;
        end else begin
            pin_prev      <= pin_level;
            prev_valid    <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            change_status <= `IOL_RST_CHANGE;
        end else begin
            change_status <= next_change;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt line
    // ------------------------------------------------------------------
    wire logic next_irq;

    // Built from next values so the line tracks the status register
    // Mask writes and read-clear reach the line at the same edge
    assign next_irq = |(next_change & next_mask);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            change_irq <= 1'b0;
        end else begin
            change_irq <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Pad control
    // ------------------------------------------------------------------
    wire io_line_pkg::line_vec_t line_data;
    wire io_line_pkg::line_vec_t line_en;

    wire io_line_pkg::line_vec_t next_pin_out;
    wire io_line_pkg::line_vec_t next_pin_oe;

    // Peripheral choice only matters where the line is not owned
    assign line_data = (line_pio_owned & out_level)
                     | (~line_pio_owned & ~fs_sc.state & periph_a_dout)
                     | (~line_pio_owned & fs_sc.state & periph_b_dout);
    assign line_en   = (line_pio_owned & line_drive_en)
                     | (~line_pio_owned & ~fs_sc.state & periph_a_oe)
                     | (~line_pio_owned & fs_sc.state & periph_b_oe);

    // Open-drain lines drive low only and float for a one
    assign next_pin_out = line_data & ~od_sc.state;
    assign next_pin_oe  = line_en
                          & (~od_sc.state | ~line_data);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_out      <= 32'h0000_0000;
            pin_oe       <= 32'h0000_0000;
        end else begin
            pin_out      <= next_pin_out;
            pin_oe       <= next_pin_oe;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pullup_on    <= `IOL_RST_PULLUP_ON;
            func_b_route <= `IOL_RST_FUNC_B;
        end else begin
            pullup_on    <= pu_sc.state;
            func_b_route <= fs_sc.state;
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    wire io_line_pkg::line_vec_t rd_data;

    // Write-only and unmapped words read as zero
    assign rd_data =
        hit_change    ? change_status    :
        hit_od_stat   ? od_sc.state      :
        hit_pu_stat   ? ~pu_sc.state     :
        hit_fs_stat   ? fs_sc.state      :
        hit_dw_stat   ? dw_sc.state      :
        hit_out_level ? out_level        :
        hit_mask      ? change_irq_mask  :
                        32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_ack   <= 1'b0;
        end else begin
            wb_ack   <= req_live;
        end
    end

    // Read data drops to zero with ack so no stale word lingers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_dat_r <= rd_live ? rd_data : 32'h0000_0000;
        end
    end

endmodule : io_line_config_status_bank

// *** io_pad_model.sv ***
// Pad model for the 32 I/O lines of the configuration bank.
// Assumes the bank drives pin_out/pin_oe and the bench drives far ends.
`timescale 1ns/100ps

module io_pad_model (
    input  wire logic                   mclk,
    input  wire io_line_pkg::line_vec_t pin_out,
    input  wire io_line_pkg::line_vec_t pin_oe,
    input  wire io_line_pkg::line_vec_t pullup_on,
    input  wire io_line_pkg::line_vec_t ext_val,
    input  wire io_line_pkg::line_vec_t ext_en,
    output io_line_pkg::line_vec_t      pin_level
);
    // Undriven line with no pull-up wanders each cycle, not a fixed level
    logic flip = 1'b0;

    always_ff @(posedge mclk) begin
        flip <= ~flip;
    end

    wire io_line_pkg::line_vec_t dev_lvl = pin_oe & pin_out;
    wire io_line_pkg::line_vec_t ext_lvl = ~pin_oe & ext_en & ext_val;
    wire io_line_pkg::line_vec_t free    = ~pin_oe & ~ext_en;
    // Released open-drain line rests on its pull-up
    assign pin_level = dev_lvl | ext_lvl | (free & pullup_on)
                     | (free & ~pullup_on & {32{flip}});
endmodule : io_pad_model

// *** io_line_bank_checker.sv ***
// Port checker for the I/O line configuration and status bank.
// Assumes one clock, mclk, and synchronous active-low rst_b.
`timescale 1ns/100ps

module io_line_bank_checker (
    input wire logic                   mclk,
    input wire logic                   rst_b,
    input wire logic                   wb_cyc,
    input wire logic                   wb_stb,
    input wire logic                   wb_we,
    input wire io_line_pkg::bus_addr_t wb_adr,
    input wire io_line_pkg::lane_sel_t wb_sel,
    input wire io_line_pkg::line_vec_t wb_dat_w,
    input wire io_line_pkg::line_vec_t wb_dat_r,
    input wire logic                   wb_ack,
    input wire io_line_pkg::line_vec_t pin_in,
    input wire io_line_pkg::line_vec_t pin_out,
    input wire io_line_pkg::line_vec_t pullup_on,
    input wire io_line_pkg::line_vec_t func_b_route,
    input wire logic                   change_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    wire take   = wb_cyc && wb_stb && !wb_ack;
    wire wr_all = take && wb_we && (wb_sel == 4'hf);

    sequence s_wr(ofs);
        wr_all && (wb_adr == ofs);
    endsequence
    // Pads quiet long enough that no change is still in the synchroniser
    sequence s_quiet_read;
        $stable(pin_in) [*6] ##0 (take && !wb_we && (wb_adr == 8'h00));
    endsequence

    property p_ack_next;
        take |=> wb_ack;
    endproperty
    property p_ack_pulse;
        wb_ack |=> !wb_ack;
    endproperty
    property p_dat_idle;
        !wb_ack |-> (wb_dat_r == 32'h0000_0000);
    endproperty
    property p_pu_off;
        s_wr(8'h10) |-> ##2 ((pullup_on & $past(wb_dat_w, 2)) == 32'h0);
    endproperty
    property p_pu_on;
        s_wr(8'h14) |-> ##2
            ((pullup_on & $past(wb_dat_w, 2)) == $past(wb_dat_w, 2));
    endproperty
    property p_func_a;
        s_wr(8'h1c) |-> ##2 ((func_b_route & $past(wb_dat_w, 2)) == 32'h0);
    endproperty
    property p_func_b;
        s_wr(8'h20) |-> ##2
            ((func_b_route & $past(wb_dat_w, 2)) == $past(wb_dat_w, 2));
    endproperty
    property p_od_low;
        s_wr(8'h04) |-> ##2 ((pin_out & $past(wb_dat_w, 2)) == 32'h0);
    endproperty
    property p_clear;
        s_quiet_read |=> !change_irq;
    endproperty

    a_ack_next:  assert property (p_ack_next)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_dat_idle:  assert property (p_dat_idle)
        else $error("read data not zero outside ack");
    a_pu_off:    assert property (p_pu_off)
        else $error("pull-up still on after disable");
    a_pu_on:     assert property (p_pu_on)
        else $error("pull-up still off after enable");
    a_func_a:    assert property (p_func_a)
        else $error("line not routed to function A");
    a_func_b:    assert property (p_func_b)
        else $error("line not routed to function B");
    a_od_low:    assert property (p_od_low)
        else $error("open-drain line drives high data");
    a_clear:     assert property (p_clear)
        else $error("interrupt stays after quiet status read");
endmodule : io_line_bank_checker

bind io_line_config_status_bank io_line_bank_checker u_io_line_bank_checker (
    .mclk, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
    .wb_dat_r, .wb_ack, .pin_in, .pin_out, .pullup_on, .func_b_route,
    .change_irq
);

// *** io_line_config_status_bank_test.sv ***
// Self-checking bench for the I/O line configuration and status bank.
// Assumes io_pad_model for the pads; lines 16-31 driven from the bench.
`timescale 1ns/100ps

module io_line_config_status_bank_test;
    logic                   mclk = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   wb_cyc = 1'b0;
    logic                   wb_stb = 1'b0;
    logic                   wb_we = 1'b0;
    io_line_pkg::bus_addr_t wb_adr = 8'h00;
    io_line_pkg::lane_sel_t wb_sel = 4'h0;
    io_line_pkg::line_vec_t wb_dat_w = 32'h0;
    io_line_pkg::line_vec_t wb_dat_r, pin_in, pin_out, pin_oe;
    io_line_pkg::line_vec_t pullup_on, func_b_route;
    logic                   wb_ack, change_irq;
    io_line_pkg::line_vec_t ext_val = 32'h0;
    io_line_pkg::line_vec_t ext_en = 32'hffff_0000;
    io_line_pkg::line_vec_t drive_en = 32'h0000_ffff;
    io_line_pkg::line_vec_t owned = 32'hffff_ffff;
    int                     miscompares = 0;
    int                     samples_checked = 0;

    always #12.5 mclk = ~mclk;

    io_line_config_status_bank u_io_line_config_status_bank (
        .mclk(mclk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .pin_in(pin_in), .line_pio_owned(owned),
        .line_drive_en(drive_en), .periph_a_dout(32'h0),
        .periph_a_oe(32'hffff_ffff), .periph_b_dout(32'hffff_ffff),
        .periph_b_oe(32'hffff_ffff),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .func_b_route(func_b_route), .change_irq(change_irq));

    io_pad_model u_io_pad_model (
        .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en),
        .pin_level(pin_in));

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input io_line_pkg::line_vec_t exp,
                       input io_line_pkg::line_vec_t got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Ack and read data taken at the rising edge that sees ack high
    task automatic xfer(input logic we, input io_line_pkg::bus_addr_t a,
                        input io_line_pkg::line_vec_t d,
                        output io_line_pkg::line_vec_t q);
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat_w <= d;
        do begin
            @(posedge mclk);
        end while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : xfer

    task automatic wr(input io_line_pkg::bus_addr_t a,
                      input io_line_pkg::line_vec_t d);
        io_line_pkg::line_vec_t q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string what, input io_line_pkg::bus_addr_t a,
                      input io_line_pkg::line_vec_t exp);
        io_line_pkg::line_vec_t q;
        xfer(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask : rd

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk("pullup_on", 32'hffff_ffff, pullup_on);
        rd("change", 8'h00, 32'h0);
        wr(8'h0c, 32'hffff_ffff);
        rd("od status", 8'h0c, 32'h0);
        rd("pu status", 8'h18, 32'h0);
        rd("func status", 8'h24, 32'h0);
        rd("dw status", 8'h30, 32'h0);
        rd("unmapped", 8'h3c, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_pullup_func;
        wr(8'h10, 32'h8000_0001);
        rd("pu status", 8'h18, 32'h8000_0001);
        chk("pullup_on", 32'h7fff_fffe, pullup_on);
        wr(8'h14, 32'h0000_0001);
        rd("pu status", 8'h18, 32'h8000_0000);
        wr(8'h20, 32'ha5a5_a5a5);
        rd("func status", 8'h24, 32'ha5a5_a5a5);
        chk("func_b_route", 32'ha5a5_a5a5, func_b_route);
        wr(8'h1c, 32'h0000_00ff);
        rd("func status", 8'h24, 32'ha5a5_a500);
        owned <= 32'hffff_00ff;
        repeat (2) @(posedge mclk);
        chk("pin_out", 32'h0000_a500, pin_out & 32'h0000_ff00);
        owned <= 32'hffff_ffff;
        $display("test pullup and function done");
    endtask : t_pullup_func

    task automatic t_drive;
        wr(8'h04, 32'h0000_000f);
        rd("od status", 8'h0c, 32'h0000_000f);
        wr(8'h08, 32'h0000_0003);
        rd("od status", 8'h0c, 32'h0000_000c);
        wr(8'h28, 32'hffff_ffff);
        rd("dw status", 8'h30, 32'hffff_ffff);
        wr(8'h34, 32'hffff_ffff);
        rd("out level", 8'h34, 32'hffff_ffff);
        chk("pin_out", 32'h0000_fff3, pin_out & 32'h0000_ffff);
        chk("pin_oe", 32'h0000_fff3, pin_oe & 32'h0000_ffff);
        wr(8'h2c, 32'hffff_0004);
        rd("dw status", 8'h30, 32'h0000_fffb);
        wr(8'h34, 32'h0);
        rd("out level", 8'h34, 32'hffff_0004);
        chk("pin_out", 32'h0, pin_out & 32'h0000_ffff);
        chk("pin_oe", 32'h0000_fffb, pin_oe & 32'h0000_ffff);
        $display("test drive done");
    endtask : t_drive

    task automatic t_change;
        io_line_pkg::line_vec_t q;
        wr(8'h38, 32'h0010_0000);
        rd("mask", 8'h38, 32'h0010_0000);
        xfer(1'b0, 8'h00, 32'h0, q);
        repeat (8) @(negedge mclk);
        rd("change", 8'h00, 32'h0);
        @(posedge mclk);
        ext_val <= 32'h0010_0000;
        repeat (8) @(negedge mclk);
        chk("irq", 32'h1, {31'h0, change_irq});
        rd("change", 8'h00, 32'h0010_0000);
        repeat (2) @(negedge mclk);
        chk("irq", 32'h0, {31'h0, change_irq});
        rd("change", 8'h00, 32'h0);
        @(posedge mclk);
        ext_val <= 32'h0030_0000;
        repeat (8) @(negedge mclk);
        chk("irq", 32'h0, {31'h0, change_irq});
        rd("change", 8'h00, 32'h0020_0000);
        $display("test change done");
    endtask : t_change

    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_pullup_func();
        t_drive();
        t_change();
        end_sim();
    end

    // Whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        end_sim();
    end
endmodule : io_line_config_status_bank_test
